// ==== verilog/frame_pkg.sv ====
// Shared constants and types for the stack frame sequencer.
package frame_pkg;

  localparam logic [11:0] OFF_CTRL     = 12'h000;
  localparam logic [11:0] OFF_STATUS   = 12'h004;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h008;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h00C;
  localparam logic [11:0] OFF_COUNT    = 12'h010;

  localparam int CTRL_EN_BIT   = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_EXC_LSB  = 4;
  localparam int IRQ_DONE_BIT  = 0;
  localparam int IRQ_EXC_BIT   = 1;

  localparam logic       CTRL_EN_RESET  = 1'h1;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

  localparam logic [4:0] REG_ARG_TOP = 5'h07;
  localparam logic [4:0] REG_S0      = 5'h10;
  localparam logic [4:0] REG_S1      = 5'h11;
  localparam logic [4:0] REG_XS_TOP  = 5'h1E;
  localparam logic [4:0] REG_SP      = 5'h1D;
  localparam logic [4:0] REG_RET     = 5'h1F;
  localparam logic [2:0] XS_USES_TOP = 3'h7;

  localparam int          FRAME_SHIFT    = 3;
  localparam logic [31:0] WORD_STEP      = 32'h0000_0004;
  localparam logic [31:0] BASIC_ZERO_ADJ = 32'h0000_0080;
  localparam int          PLAN_DEPTH     = 16;

  typedef enum logic [2:0] {
    EXC_NONE     = 3'h0,
    EXC_REFILL   = 3'h1,
    EXC_INVALID  = 3'h2,
    EXC_MODIFIED = 3'h3,
    EXC_ADDR     = 3'h4,
    EXC_BUS      = 3'h5
  } exc_code_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_ISSUE  = 4'h2,
    ST_WAIT   = 4'h4,
    ST_FINISH = 4'h8
  } seq_state_t;

endpackage : frame_pkg

// ==== verilog/stack_frame_seq.sv ====
// Sequencer for the extended frame unwind and the basic frame setup.
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
module stack_frame_seq (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        start,
  input  wire logic        is_unwind,
  input  wire logic        return_link_flag,
  input  wire logic        first_saved_flag,
  input  wire logic        second_saved_flag,
  input  wire logic [2:0]  xs_count,
  input  wire logic [3:0]  arg_code,
  input  wire logic [7:0]  frame_size,
  input  wire logic [31:0] sp_in,
  output logic             busy,
  output logic             done,
  output logic [4:0]       rf_rd_idx,
  input  wire logic [31:0] rf_rd_data,
  output logic             rf_we,
  output logic [4:0]       rf_wr_idx,
  output logic [31:0]      rf_wr_data,
  output logic             mem_req,
  output logic             mem_we,
  output logic [31:0]      mem_addr,
  output logic [31:0]      mem_wdata,
  input  wire logic        mem_ready,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        mem_refill,
  input  wire logic        mem_invalid,
  input  wire logic        mem_modified,
  input  wire logic        mem_bus_err,
  output logic             exc_valid,
  output logic [2:0]       exc_code,
  output logic [31:0]      exc_vaddr
);

  frame_pkg::seq_state_t state_q;
  logic [4:0]  plan_q [frame_pkg::PLAN_DEPTH];
  logic [4:0]  plan_d [frame_pkg::PLAN_DEPTH];
  logic [3:0]  len_q, len_d, idx_q;
  logic [2:0]  astatic_d, astatic_q, xs_q;
  logic        unwind_q, ret_q, accept, misaligned, last_xfer;
  logic [7:0]  fs_q;
  logic [31:0] sp_q, base_d, base_q, addr_q, last_addr_q;
  logic [31:0] unwind_top, setup_sp;
  logic        mem_req_q, mem_we_q, rf_we_q, exc_valid_q, done_q;
  logic [31:0] mem_addr_q, mem_wdata_q, rf_wr_data_q, exc_vaddr_q;
  logic [4:0]  rf_wr_idx_q;
  frame_pkg::exc_code_t exc_code_q, bus_exc;
  logic        ctrl_en_q, pslverr_q;
  logic [1:0]  irq_stat_q, irq_mask_q, irq_set;
  logic [31:0] prdata_q, count_q;

  // Static count of the argument code; the all-ones code is never issued.
  always_comb begin
    unique case (arg_code)
      4'h1, 4'h5, 4'h9, 4'hD: astatic_d = 3'h1;
      4'h2, 4'h6, 4'hA:       astatic_d = 3'h2;
      4'h3, 4'h7:             astatic_d = 3'h3;
      4'hB:                   astatic_d = 3'h4;
      default:                astatic_d = 3'h0;
    endcase
  end

  // Transfer order: the address only ever falls, so the list is the register order.
  always_comb begin
    for (int i = 0; i < frame_pkg::PLAN_DEPTH; i++) begin
      plan_d[i] = 5'h00;
    end
    len_d = 4'h0;
    if (return_link_flag) begin
      plan_d[len_d] = frame_pkg::REG_RET;
      len_d = len_d + 4'h1;
    end
    if (is_unwind) begin
      for (int k = 7; k >= 1; k--) begin
        if (xs_count >= 3'(k)) begin
          plan_d[len_d] = (3'(k) == frame_pkg::XS_USES_TOP) ? frame_pkg::REG_XS_TOP
                                                            : 5'(17 + k);
          len_d = len_d + 4'h1;
        end
      end
    end
    if (second_saved_flag) begin
      plan_d[len_d] = frame_pkg::REG_S1;
      len_d = len_d + 4'h1;
    end
    if (first_saved_flag) begin
      plan_d[len_d] = frame_pkg::REG_S0;
      len_d = len_d + 4'h1;
    end
    if (is_unwind) begin
      for (int k = 0; k < 4; k++) begin
        if (3'(k) < astatic_d) begin
          plan_d[len_d] = frame_pkg::REG_ARG_TOP - 5'(k);
          len_d = len_d + 4'h1;
        end
      end
    end
  end

  assign base_d     = is_unwind ? sp_in + {21'h0, frame_size, 3'h0} : sp_in;
  assign misaligned = sp_in[1:0] != 2'h0;
  assign accept     = start && ctrl_en_q && (state_q == frame_pkg::ST_IDLE);
  assign last_xfer  = idx_q == len_q - 4'h1;
  assign rf_rd_idx  = plan_q[idx_q];
  assign unwind_top = sp_q + ({24'h0, fs_q} << frame_pkg::FRAME_SHIFT);
  // Only the low four bits form the basic setup's frame size field.
  assign setup_sp   = (fs_q[3:0] == 4'h0) ? sp_q - frame_pkg::BASIC_ZERO_ADJ
                    : sp_q - ({28'h0, fs_q[3:0]} << frame_pkg::FRAME_SHIFT);

  // Translation faults outrank a bus error; loads never report modified.
  always_comb begin
    if (mem_refill) bus_exc = frame_pkg::EXC_REFILL;
    else if (mem_invalid) bus_exc = frame_pkg::EXC_INVALID;
    else if (mem_modified && !unwind_q) bus_exc = frame_pkg::EXC_MODIFIED;
    else if (mem_bus_err) bus_exc = frame_pkg::EXC_BUS;
    else bus_exc = frame_pkg::EXC_NONE;
  end

  // Sequencer state and operand capture.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q     <= frame_pkg::ST_IDLE;
      len_q       <= 4'h0;
      idx_q       <= 4'h0;
      unwind_q    <= 1'h0;
      ret_q       <= 1'h0;
      xs_q        <= 3'h0;
      astatic_q   <= 3'h0;
      fs_q        <= 8'h00;
      sp_q        <= 32'h0000_0000;
      base_q      <= 32'h0000_0000;
      addr_q      <= 32'h0000_0000;
      last_addr_q <= 32'h0000_0000;
      for (int i = 0; i < frame_pkg::PLAN_DEPTH; i++) begin
        plan_q[i] <= 5'h00;
      end
    end else begin
      unique case (state_q)
        frame_pkg::ST_IDLE: begin
          if (accept) begin
            plan_q    <= plan_d;
            len_q     <= len_d;
            idx_q     <= 4'h0;
            unwind_q  <= is_unwind;
            ret_q     <= return_link_flag;
            xs_q      <= xs_count;
            astatic_q <= astatic_d;
            fs_q      <= frame_size;
            sp_q      <= sp_in;
            base_q    <= base_d;
            addr_q    <= base_d - frame_pkg::WORD_STEP;
            if (misaligned && len_d != 4'h0) state_q <= frame_pkg::ST_IDLE;
            else if (len_d == 4'h0) state_q <= frame_pkg::ST_FINISH;
            else state_q <= frame_pkg::ST_ISSUE;
          end
        end
        frame_pkg::ST_ISSUE: begin
          if (addr_q[1:0] != 2'h0) state_q <= frame_pkg::ST_IDLE;
          else state_q <= frame_pkg::ST_WAIT;
        end
        frame_pkg::ST_WAIT: begin
          if (mem_ready) begin
            if (bus_exc != frame_pkg::EXC_NONE) begin
              state_q <= frame_pkg::ST_IDLE;
            end else begin
              last_addr_q <= addr_q;
              addr_q      <= addr_q - frame_pkg::WORD_STEP;
              idx_q       <= idx_q + 4'h1;
              state_q     <= last_xfer ? frame_pkg::ST_FINISH : frame_pkg::ST_ISSUE;
            end
          end
        end
        frame_pkg::ST_FINISH: state_q <= frame_pkg::ST_IDLE;
      endcase
    end
  end

  // Memory port: the request holds steady until the port answers.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mem_req_q   <= 1'h0;
      mem_we_q    <= 1'h0;
      mem_addr_q  <= 32'h0000_0000;
      mem_wdata_q <= 32'h0000_0000;
    end else if (state_q == frame_pkg::ST_ISSUE && addr_q[1:0] == 2'h0) begin
      mem_req_q   <= 1'h1;
      mem_we_q    <= !unwind_q;
      mem_addr_q  <= addr_q;
      mem_wdata_q <= rf_rd_data;
    end else if (state_q == frame_pkg::ST_WAIT && mem_ready) begin
      mem_req_q   <= 1'h0;
    end
  end

  // Register file writes: loaded words, then the stack pointer last of all.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rf_we_q      <= 1'h0;
      rf_wr_idx_q  <= 5'h00;
      rf_wr_data_q <= 32'h0000_0000;
    end else begin
      rf_we_q <= 1'h0;
      if (state_q == frame_pkg::ST_WAIT && mem_ready && unwind_q
          && bus_exc == frame_pkg::EXC_NONE) begin
        rf_we_q      <= 1'h1;
        rf_wr_idx_q  <= plan_q[idx_q];
        rf_wr_data_q <= mem_rdata;
      end else if (state_q == frame_pkg::ST_FINISH) begin
        rf_we_q      <= 1'h1;
        rf_wr_idx_q  <= frame_pkg::REG_SP;
        rf_wr_data_q <= unwind_q ? unwind_top : setup_sp;
      end
    end
  end

  // Exception and completion pulses; a restart is left to the core's exception return.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      exc_valid_q <= 1'h0;
      exc_code_q  <= frame_pkg::EXC_NONE;
      exc_vaddr_q <= 32'h0000_0000;
      done_q      <= 1'h0;
      count_q     <= 32'h0000_0000;
    end else begin
      exc_valid_q <= 1'h0;
      done_q      <= 1'h0;
      if (accept && misaligned && len_d != 4'h0) begin
        exc_valid_q <= 1'h1;
        exc_code_q  <= frame_pkg::EXC_ADDR;
        exc_vaddr_q <= base_d - frame_pkg::WORD_STEP;
      end else if (state_q == frame_pkg::ST_ISSUE && addr_q[1:0] != 2'h0) begin
        exc_valid_q <= 1'h1;
        exc_code_q  <= frame_pkg::EXC_ADDR;
        exc_vaddr_q <= addr_q;
      end else if (state_q == frame_pkg::ST_WAIT && mem_ready
                   && bus_exc != frame_pkg::EXC_NONE) begin
        exc_valid_q <= 1'h1;
        exc_code_q  <= bus_exc;
        exc_vaddr_q <= addr_q;
      end else if (state_q == frame_pkg::ST_FINISH) begin
        done_q  <= 1'h1;
        count_q <= count_q + 32'h0000_0001;
      end
    end
  end

  // APB slave with no wait states; read data is fetched in the setup cycle.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_en_q  <= frame_pkg::CTRL_EN_RESET;
      irq_mask_q <= frame_pkg::IRQ_MASK_RESET;
      prdata_q   <= 32'h0000_0000;
      pslverr_q  <= 1'h0;
    end else if (psel && !penable) begin
      pslverr_q <= !(paddr inside {frame_pkg::OFF_CTRL, frame_pkg::OFF_STATUS,
                   frame_pkg::OFF_IRQ_STAT, frame_pkg::OFF_IRQ_MASK, frame_pkg::OFF_COUNT});
      prdata_q  <= 32'h0000_0000;
      unique case (paddr)
        frame_pkg::OFF_CTRL:     prdata_q[frame_pkg::CTRL_EN_BIT] <= ctrl_en_q;
        frame_pkg::OFF_STATUS: begin
          prdata_q[frame_pkg::STAT_BUSY_BIT] <= state_q != frame_pkg::ST_IDLE;
          prdata_q[frame_pkg::STAT_EXC_LSB +: 3] <= exc_code_q;
        end
        frame_pkg::OFF_IRQ_STAT: prdata_q[1:0] <= irq_stat_q;
        frame_pkg::OFF_IRQ_MASK: prdata_q[1:0] <= irq_mask_q;
        frame_pkg::OFF_COUNT:    prdata_q <= count_q;
        default:                 prdata_q <= 32'h0000_0000;
      endcase
    end else if (psel && penable && pwrite) begin
      if (paddr == frame_pkg::OFF_CTRL) ctrl_en_q <= pwdata[frame_pkg::CTRL_EN_BIT];
      if (paddr == frame_pkg::OFF_IRQ_MASK) irq_mask_q <= pwdata[1:0];
    end
  end

  // Sticky events, write one to clear; a new event in the clearing cycle is kept.
  assign irq_set = {exc_valid_q, done_q};
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_stat_q <= 2'h0;
    end else if (psel && penable && pwrite && paddr == frame_pkg::OFF_IRQ_STAT) begin
      irq_stat_q <= (irq_stat_q & ~pwdata[1:0]) | irq_set;
    end else begin
      irq_stat_q <= irq_stat_q | irq_set;
    end
  end

  assign prdata     = prdata_q;
  assign pready     = 1'h1;
  assign pslverr    = pslverr_q;
  assign irq        = |(irq_stat_q & irq_mask_q);
  assign busy       = state_q != frame_pkg::ST_IDLE;
  assign done       = done_q;
  assign rf_we      = rf_we_q;
  assign rf_wr_idx  = rf_wr_idx_q;
  assign rf_wr_data = rf_wr_data_q;
  assign mem_req    = mem_req_q;
  assign mem_we     = mem_we_q;
  assign mem_addr   = mem_addr_q;
  assign mem_wdata  = mem_wdata_q;
  assign exc_valid  = exc_valid_q;
  assign exc_code   = exc_code_q;
  assign exc_vaddr  = exc_vaddr_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_first_issue;
    $rose(mem_req_q) && idx_q == 4'h0;
  endsequence
  sequence s_fin_unwind;
    state_q == frame_pkg::ST_FINISH && unwind_q;
  endsequence
  sequence s_fin_setup;
    state_q == frame_pkg::ST_FINISH && !unwind_q;
  endsequence

  property p_first_addr;
    s_first_issue |-> mem_addr_q == base_q - frame_pkg::WORD_STEP
      && (!ret_q || plan_q[0] == frame_pkg::REG_RET);
  endproperty
  a_first_addr: assert property (p_first_addr) else $error("first transfer address wrong");

  property p_step;
    ($rose(mem_req_q) && idx_q != 4'h0) |-> mem_addr_q == last_addr_q - frame_pkg::WORD_STEP;
  endproperty
  a_step: assert property (p_step) else $error("address did not fall by one word");

  property p_xs_top;
    (rf_we_q && unwind_q && rf_wr_idx_q == frame_pkg::REG_XS_TOP)
      |-> xs_q == frame_pkg::XS_USES_TOP;
  endproperty
  a_xs_top: assert property (p_xs_top) else $error("register 30 loaded below count 7");

  property p_statics;
    (rf_we_q && rf_wr_idx_q <= frame_pkg::REG_ARG_TOP)
      |-> rf_wr_idx_q + {2'h0, astatic_q} >= 5'h08;
  endproperty
  a_statics: assert property (p_statics) else $error("argument register reloaded");

  property p_unwind_sp;
    s_fin_unwind |=> rf_we_q && rf_wr_idx_q == frame_pkg::REG_SP
      && rf_wr_data_q == $past(unwind_top);
  endproperty
  a_unwind_sp: assert property (p_unwind_sp) else $error("unwind sp wrong");

  property p_setup_sp;
    (s_fin_setup ##0 fs_q[3:0] == 4'h0)
      |=> rf_wr_data_q == $past(sp_q) - frame_pkg::BASIC_ZERO_ADJ;
  endproperty
  a_setup_sp: assert property (p_setup_sp) else $error("zero frame setup sp wrong");

  property p_misalign;
    (accept && misaligned && len_d != 4'h0) |=> exc_valid_q
      && exc_code_q == frame_pkg::EXC_ADDR && !mem_req_q ##1 !mem_req_q;
  endproperty
  a_misalign: assert property (p_misalign) else $error("misaligned sp not trapped");

  property p_word;
    mem_req_q |-> mem_addr_q[1:0] == 2'h0 && mem_we_q == !unwind_q;
  endproperty
  a_word: assert property (p_word) else $error("transfer misaligned or wrong kind");

  property p_no_mod;
    (exc_valid_q && unwind_q) |-> exc_code_q != frame_pkg::EXC_MODIFIED;
  endproperty
  a_no_mod: assert property (p_no_mod) else $error("unwind reported modified");

  property p_sp_late;
    (rf_we_q && rf_wr_idx_q == frame_pkg::REG_SP) |-> $past(state_q) == frame_pkg::ST_FINISH;
  endproperty
  a_sp_late: assert property (p_sp_late) else $error("sp written early");

  property p_abort;
    exc_valid_q |-> state_q == frame_pkg::ST_IDLE && !rf_we_q ##1 !rf_we_q;
  endproperty
  a_abort: assert property (p_abort) else $error("work went on after exception");

endmodule : stack_frame_seq

// ==== sim/frame_mem_model.sv ====
// Behavioural data memory and translation port facing the sequencer.
`timescale 1ns/1ns
module frame_mem_model (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        busy,
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  input  wire logic [3:0]  wait_cycles,
  input  wire logic [2:0]  err_kind,
  input  wire logic [4:0]  err_at,
  output logic             mem_ready,
  output logic [31:0]      mem_rdata,
  output logic             mem_refill,
  output logic             mem_invalid,
  output logic             mem_modified,
  output logic             mem_bus_err
);
  logic [3:0] wait_q;
  logic [4:0] xfer_q;
  logic       hit;
  assign hit = (err_at == xfer_q);
  // Read data toggles outside an answer, so a capture at the wrong edge shows up.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      {mem_ready, mem_refill, mem_invalid, mem_modified, mem_bus_err} <= 5'h00;
      wait_q <= 4'h0;
      xfer_q <= 5'h00;
      mem_rdata <= 32'h0000_0000;
    end else begin
      mem_rdata <= ~mem_rdata;
      {mem_ready, mem_refill, mem_invalid, mem_modified, mem_bus_err} <= 5'h00;
      if (!busy) xfer_q <= 5'h00;
      if (mem_ready) begin
        wait_q <= 4'h0;
        xfer_q <= xfer_q + 5'h01;
      end else if (mem_req && wait_q == wait_cycles) begin
        mem_ready <= 1'b1;
        mem_rdata <= mem_addr ^ 32'h3C3C_0000;
        mem_refill <= hit && err_kind == 3'h1;
        mem_invalid <= hit && err_kind == 3'h2;
        mem_modified <= hit && err_kind == 3'h3;
        mem_bus_err <= hit && err_kind == 3'h4;
      end else if (mem_req) begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule : frame_mem_model

// ==== sim/stack_frame_seq_bench.sv ====
// Self-checking bench for the stack frame sequencer.
`timescale 1ns/1ns
module stack_frame_seq_bench;
  logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, irq, start, is_unwind;
  logic        return_link_flag, first_saved_flag, second_saved_flag, busy, done, rf_we;
  logic        mem_req, mem_we, mem_ready, mem_refill, mem_invalid, mem_modified;
  logic        mem_bus_err, exc_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, sp_in, rf_rd_data, rf_wr_data, mem_addr, mem_wdata;
  logic [31:0] mem_rdata, exc_vaddr;
  logic [4:0]  rf_rd_idx, rf_wr_idx, err_at;
  logic [2:0]  xs_count, exc_code, err_kind;
  logic [3:0]  arg_code, wait_cycles;
  logic [7:0]  frame_size;
  int          fail_count, total_checks, done_count;
  logic [31:0] ma[$], md[$], rd[$];
  logic        mw[$];
  logic [4:0]  ri[$];

  stack_frame_seq DUT (.*);
  frame_mem_model MEM (.*);

  // Register file contents follow the index so every store is traceable.
  assign rf_rd_data = {27'h0, rf_rd_idx} ^ 32'hA5A5_0000;

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (mem_req === 1'b1 && mem_ready === 1'b1) begin
      ma.push_back(mem_addr);
      mw.push_back(mem_we);
      md.push_back(mem_wdata);
    end
    if (rf_we === 1'b1) begin
      ri.push_back(rf_wr_idx);
      rd.push_back(rf_wr_data);
    end
  end

  task automatic tally_and_finish;
    if (fail_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, x, r);
    chk("pslverr", {31'h0, xe}, {31'h0, e});
  endtask : rdc

  task automatic run(input logic u, ra, s1, s0, input logic [2:0] xs, input logic [3:0] ac,
                     input logic [7:0] fs, input logic [31:0] sp, input logic [2:0] ek,
                     input int ea, input logic [3:0] w);
    logic [4:0]  ix[$];
    logic [31:0] base, nsp;
    logic [2:0]  ec;
    logic        gd, gx;
    int          n, ns, nm, nr;
    ma.delete();
    mw.delete();
    md.delete();
    ri.delete();
    rd.delete();
    base = u ? sp + {21'h0, fs, 3'h0} : sp;
    nsp = u ? base : sp - ((fs[3:0] == 4'h0) ? frame_pkg::BASIC_ZERO_ADJ : {25'h0, fs[3:0], 3'h0});
    if (ra) ix.push_back(frame_pkg::REG_RET);
    if (u && xs == 3'h7) ix.push_back(frame_pkg::REG_XS_TOP);
    for (int k = (xs > 3'h6 ? 6 : int'(xs)) - 1; u && k >= 0; k--) ix.push_back(5'h12 + 5'(k));
    if (s1) ix.push_back(frame_pkg::REG_S1);
    if (s0) ix.push_back(frame_pkg::REG_S0);
    ns = (ac == 4'hB) ? 4 : (ac[3:2] == 2'h3 && ac[1]) ? 0 : int'(ac[1:0]);
    for (int k = 0; u && k < ns; k++) ix.push_back(5'h07 - 5'(k));
    n = ix.size();
    ec = (ek == 3'h4) ? 3'h5 : ek;
    if (ek == 3'h0 || ea >= n || (u && ek == 3'h3)) ec = 3'h0;
    if (sp[1:0] != 2'h0 && n > 0) ec = 3'h4;
    nm = (ec == 3'h4) ? 0 : (ec != 3'h0) ? ea + 1 : n;
    nr = (ec == 3'h4) ? 0 : (ec != 3'h0) ? (u ? ea : 0) : (u ? n : 0) + 1;
    if (ec == 3'h0) done_count++;
    @(posedge sys_clk);
    start <= 1'b1;
    is_unwind <= u;
    {return_link_flag, second_saved_flag, first_saved_flag} <= {ra, s1, s0};
    xs_count <= xs;
    arg_code <= ac;
    frame_size <= fs;
    sp_in <= sp;
    err_kind <= ek;
    err_at <= 5'(ea);
    wait_cycles <= w;
    @(posedge sys_clk);
    start <= 1'b0;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (done !== 1'b1 && exc_valid !== 1'b1 && n < 400);
    gd = done;
    gx = exc_valid;
    @(negedge sys_clk);
    n = ix.size();
    chk("done", {31'h0, ec == 3'h0}, {31'h0, gd});
    chk("exc_valid", {31'h0, ec != 3'h0}, {31'h0, gx});
    if (ec != 3'h0) begin
      chk("exc_code", {29'h0, ec}, {29'h0, exc_code});
      chk("exc_vaddr", base - 32'((nm == 0 ? 1 : nm) * 4), exc_vaddr);
    end
    chk("mem_count", 32'(nm), 32'(ma.size()));
    chk("rf_count", 32'(nr), 32'(ri.size()));
    for (int i = 0; i < nm && i < ma.size(); i++) begin
      chk("mem_addr", base - 32'((i + 1) * 4), ma[i]);
      chk("mem_we", {31'h0, !u}, {31'h0, mw[i]});
      if (!u) chk("mem_wdata", {27'h0, ix[i]} ^ 32'hA5A5_0000, md[i]);
    end
    for (int i = 0; i < nr && i < ri.size(); i++) begin
      chk("rf_idx", {27'h0, (u && i < n) ? ix[i] : frame_pkg::REG_SP}, {27'h0, ri[i]});
      chk("rf_data", (u && i < n) ? (base - 32'((i + 1) * 4)) ^ 32'h3C3C_0000 : nsp, rd[i]);
    end
  endtask : run

  initial begin
    #2000000;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    {psel, penable, pwrite, start, is_unwind} = 5'h00;
    {return_link_flag, first_saved_flag, second_saved_flag} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    sp_in = 32'h0000_0000;
    {xs_count, err_kind, err_at} = 11'h000;
    {arg_code, wait_cycles, frame_size} = 16'h0000;
    fail_count = 0;
    total_checks = 0;
    done_count = 0;
    rst = 1'b1;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    rdc("ctrl", frame_pkg::OFF_CTRL, 32'h0000_0001, 1'b0);
    rdc("irq_mask", frame_pkg::OFF_IRQ_MASK, 32'h0000_0000, 1'b0);
    rdc("unmapped", 12'h020, 32'h0000_0000, 1'b1);
    wr(frame_pkg::OFF_IRQ_MASK, 32'h0000_0003);
    run(0, 1, 0, 0, 3'h0, 4'h0, 8'h00, 32'h0000_1000, 3'h0, 0, 4'h0);
    chk("irq", 32'h1, {31'h0, irq});
    rdc("irq_stat", frame_pkg::OFF_IRQ_STAT, 32'h0000_0001, 1'b0);
    wr(frame_pkg::OFF_IRQ_STAT, 32'h0000_0001);
    // The clear lands at the access edge, so the level is looked at half a cycle on.
    @(negedge sys_clk);
    chk("irq", 32'h0, {31'h0, irq});
    wr(frame_pkg::OFF_IRQ_MASK, 32'h0000_0000);
    run(0, 1, 1, 1, 3'h0, 4'h0, 8'h05, 32'h0000_2000, 3'h0, 0, 4'h3);
    chk("irq_masked", 32'h0, {31'h0, irq});
    rdc("irq_stat", frame_pkg::OFF_IRQ_STAT, 32'h0000_0001, 1'b0);
    run(1, 1, 1, 1, 3'h7, 4'hB, 8'hC3, 32'h0000_3000, 3'h0, 0, 4'h2);
    // The all-ones code is never sent, its outcome is left open.
    for (int c = 0; c < 15; c++) begin
      run(1, 0, 0, 0, c[2:0], c[3:0], 8'h10, 32'h0000_4000, 3'h0, 0, 4'h0);
    end
    run(1, 0, 0, 0, 3'h0, 4'h1, 8'h01, 32'h0000_5002, 3'h0, 0, 4'h0);
    run(1, 0, 0, 0, 3'h0, 4'h4, 8'h01, 32'h0000_5002, 3'h0, 0, 4'h0);
    run(0, 0, 1, 0, 3'h0, 4'h0, 8'h02, 32'h0000_6001, 3'h0, 0, 4'h0);
    run(0, 0, 0, 0, 3'h0, 4'h0, 8'h00, 32'h0000_6004, 3'h0, 0, 4'h0);
    for (int k = 1; k < 5; k++) begin
      run(1, 1, 1, 1, 3'h0, 4'h0, 8'h04, 32'h0000_7000, 3'(k), k - 1, 4'h1);
      run(0, 1, 1, 1, 3'h0, 4'h0, 8'h04, 32'h0000_7000, 3'(k), 1, 4'h0);
    end
    rdc("status", frame_pkg::OFF_STATUS, 32'h0000_0050, 1'b0);
    rdc("irq_stat_exc", frame_pkg::OFF_IRQ_STAT, 32'h0000_0003, 1'b0);
    wr(frame_pkg::OFF_CTRL, 32'h0000_0000);
    ma.delete();
    @(posedge sys_clk);
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    repeat (4) @(negedge sys_clk);
    chk("busy_disabled", 32'h0, {31'h0, busy});
    chk("mem_disabled", 32'h0, 32'(ma.size()));
    wr(frame_pkg::OFF_CTRL, 32'h0000_0001);
    rdc("count", frame_pkg::OFF_COUNT, 32'(done_count), 1'b0);
    tally_and_finish();
  end
endmodule : stack_frame_seq_bench
